// ===== core/gpio_direction_and_pin_remap.sv
// Port A (8 pins) and port B (6 pins) direction, data, pull-up, wake and
// pin remap logic, with an Avalon-MM slave for software access.
// Assumes pins arrive asynchronously and timer/analog requests come from
// logic on clock_in.
`timescale 1ns/100ps
`include "gpio_remap_cfg.svh"

// Contract
// - Direction one input, zero push-pull output
// - Input pin read returns sampled level
// - Output pin read returns latch bit
// - Port A direction eight bits reset one
// - Port B direction six bits, upper zero
// - Remap writes allowed only with key 1010
// - Remap bit3 moves irq one pin
// - Remap bit2 moves irq zero, timer clock
// - Two timers: route code places both timers
// - One timer: route code places timer output
// - Reset sets latches and directions high
// - New output drives high before latch write
// - Bit operations are whole-byte read-modify-write
// - Analog function overrides digital function; code overrides drive and pull-up only, digital inputs still follow the pin
// - Shared analog pin feeds all modules
// - Converter pins start analog, converter off
// - Enabled converter channel removes pull-up
// - Falling edge on wake pin wakes
// - Output latch holds; inputs sampled unlatched
// - Wake and pull-up enables reset zero
module gpio_direction_and_pin_remap
  import gpio_remap_pkg::*;
#(
  parameter int PA_WIDTH = 8,
  parameter int PB_WIDTH = 6,
  parameter bit TWO_TIMERS = 1'b1
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [7:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  output logic [31:0] readdata_out,
  output logic [1:0] response_out,
  output logic waitrequest_out,
  input wire logic [PA_WIDTH-1:0] pa_pin_in,
  output logic [PA_WIDTH-1:0] pa_pin_out,
  output logic [PA_WIDTH-1:0] pa_pin_oe_n_out,
  output logic [PA_WIDTH-1:0] pa_pullup_out,
  input wire logic [PB_WIDTH-1:0] pb_pin_in,
  output logic [PB_WIDTH-1:0] pb_pin_out,
  output logic [PB_WIDTH-1:0] pb_pin_oe_n_out,
  output logic [PB_WIDTH-1:0] pb_pullup_out,
  input wire logic [PA_WIDTH-1:0] pa_comparator_select_in,
  output logic [PA_WIDTH-1:0] pa_adc_connect_out,
  output logic [PA_WIDTH-1:0] pa_comparator_connect_out,
  output logic adc_power_on_out,
  input wire logic sleep_mode_in,
  output logic wake_out,
  input wire logic timer_zero_output_in,
  input wire logic timer_zero_pin_enable_in,
  input wire logic timer_one_output_in,
  input wire logic timer_one_pin_enable_in,
  output logic ext_irq_zero_input_out,
  output logic ext_irq_one_input_out,
  output logic timer_zero_clock_input_out,
  output logic timer_one_clock_input_out
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  // Routing is hard-wired to these pin counts.
  if (PA_WIDTH != 8) begin : g_bad_pa
    $error("port A must be eight pins");
  end
  if (PB_WIDTH != 6) begin : g_bad_pb
    $error("port B must be six pins");
  end

  // ************************************************************
  // Registers
  // ************************************************************
  logic [PA_WIDTH-1:0] first_port_latch_reg;
  logic [PA_WIDTH-1:0] port_a_direction_reg;
  logic [PA_WIDTH-1:0] first_port_pullup_enable_reg;
  logic [PA_WIDTH-1:0] first_port_wake_enable_reg;
  logic [PB_WIDTH-1:0] second_port_latch_reg;
  logic [PB_WIDTH-1:0] port_b_direction_reg;
  logic [PB_WIDTH-1:0] second_port_pullup_enable_reg;
  remap_t pin_remap_control_reg;
  adc_ctrl_t adc_ctrl_reg;
  logic wake_seen_reg;
  bus_state_t bus_state_reg;
  logic [PA_WIDTH-1:0] pa_level_reg;
  logic [PB_WIDTH-1:0] pb_level_reg;
  logic [PA_WIDTH-1:0] pa_level_prev_reg;

  // ************************************************************
  // Pin input filters
  // ************************************************************
  // Three stages; a change is accepted once stages two and three agree.
  logic [PA_WIDTH-1:0] pa_s1_reg;
  logic [PA_WIDTH-1:0] pa_s2_reg;
  logic [PA_WIDTH-1:0] pa_s3_reg;
  logic [PB_WIDTH-1:0] pb_s1_reg;
  logic [PB_WIDTH-1:0] pb_s2_reg;
  logic [PB_WIDTH-1:0] pb_s3_reg;

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      pa_s1_reg <= '1;
      pa_s2_reg <= '1;
      pa_s3_reg <= '1;
      pb_s1_reg <= '1;
      pb_s2_reg <= '1;
      pb_s3_reg <= '1;
    end else begin
      pa_s1_reg <= pa_pin_in;
      pa_s2_reg <= pa_s1_reg;
      pa_s3_reg <= pa_s2_reg;
      pb_s1_reg <= pb_pin_in;
      pb_s2_reg <= pb_s1_reg;
      pb_s3_reg <= pb_s2_reg;
    end
  end

  // Inputs are not latched: level follows the pin after filtering
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      pa_level_reg <= '1;
      pb_level_reg <= '1;
      pa_level_prev_reg <= '1;
    end else begin
      for (int i = 0; i < PA_WIDTH; i++) begin
        if (pa_s2_reg[i] == pa_s3_reg[i]) begin
          pa_level_reg[i] <= pa_s3_reg[i];
        end
      end
      for (int j = 0; j < PB_WIDTH; j++) begin
        if (pb_s2_reg[j] == pb_s3_reg[j]) begin
          pb_level_reg[j] <= pb_s3_reg[j];
        end
      end
      pa_level_prev_reg <= pa_level_reg;
    end
  end

  // ************************************************************
  // Bus slave
  // ************************************************************
  // One idle wait cycle, then waitrequest low for exactly one edge.
  logic write_fire;
  logic lane0_write;
  logic [7:0] wbyte;
  logic addr_hit;
  logic [31:0] read_value;

  assign write_fire = write_in && (bus_state_reg == BUS_ACK);
  assign lane0_write = write_fire && byteenable_in[0];
  assign wbyte = writedata_in[7:0];

  logic [PA_WIDTH-1:0] pa_read_mix;
  logic [PB_WIDTH-1:0] pb_read_mix;
  // Input bits show the pin, output bits the latch
  assign pa_read_mix = (port_a_direction_reg & pa_level_reg) | (~port_a_direction_reg & first_port_latch_reg);
  assign pb_read_mix = (port_b_direction_reg & pb_level_reg) | (~port_b_direction_reg & second_port_latch_reg);

  always_comb begin
    read_value = 32'h0000_0000;
    addr_hit = 1'b1;
    if (address_in == `OFS_PA_DATA) begin
      read_value[PA_WIDTH-1:0] = pa_read_mix;
    end else if (address_in == `OFS_PA_DIR) begin
      read_value[PA_WIDTH-1:0] = port_a_direction_reg;
    end else if (address_in == `OFS_PA_PULLUP) begin
      read_value[PA_WIDTH-1:0] = first_port_pullup_enable_reg;
    end else if (address_in == `OFS_PA_WAKE) begin
      read_value[PA_WIDTH-1:0] = first_port_wake_enable_reg;
    end else if (address_in == `OFS_PB_DATA) begin
      read_value[PB_WIDTH-1:0] = pb_read_mix;
    end else if (address_in == `OFS_PB_DIR) begin
      read_value[PB_WIDTH-1:0] = port_b_direction_reg;
    end else if (address_in == `OFS_PB_PULLUP) begin
      read_value[PB_WIDTH-1:0] = second_port_pullup_enable_reg;
    end else if (address_in == `OFS_REMAP) begin
      read_value[7:0] = pin_remap_control_reg;
    end else if (address_in == `OFS_ADC_CTRL) begin
      read_value[4:0] = adc_ctrl_reg;
    end else if (address_in == `OFS_STATUS) begin
      read_value[0] = wake_seen_reg;
      read_value[1] = (pin_remap_control_reg.remap_lock_key == `REMAP_UNLOCK_KEY);
    end else begin
      addr_hit = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      bus_state_reg <= BUS_IDLE;
      waitrequest_out <= 1'b1;
      readdata_out <= 32'h0000_0000;
      response_out <= `RESP_OKAY;
    end else begin
      case (bus_state_reg)
        BUS_IDLE: begin
          if (read_in || write_in) begin
            bus_state_reg <= BUS_ACK;
            waitrequest_out <= 1'b0;
            readdata_out <= read_in ? read_value : 32'h0000_0000;
            response_out <= addr_hit ? `RESP_OKAY : `RESP_SLVERR;
          end
        end
        BUS_ACK: begin
          bus_state_reg <= BUS_IDLE;
          waitrequest_out <= 1'b1;
          readdata_out <= 32'h0000_0000;
          response_out <= `RESP_OKAY;
        end
        default: begin
          bus_state_reg <= BUS_IDLE;
          waitrequest_out <= 1'b1;
        end
      endcase
    end
  end

  // ************************************************************
  // Port A registers
  // ************************************************************
  // A data write stores all bits, so a read-back-modify-write keeps
  // input pins' latches at the level they read
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      first_port_latch_reg <= `RST_PA_DATA;
    end else if (lane0_write && address_in == `OFS_PA_DATA) begin
      first_port_latch_reg <= wbyte[PA_WIDTH-1:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      port_a_direction_reg <= `RST_PA_DIR;
    end else if (lane0_write && address_in == `OFS_PA_DIR) begin
      port_a_direction_reg <= wbyte[PA_WIDTH-1:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      first_port_pullup_enable_reg <= `RST_PULLUP_A;
      first_port_wake_enable_reg <= `RST_WAKE;
    end else if (lane0_write) begin
      if (address_in == `OFS_PA_PULLUP) begin
        first_port_pullup_enable_reg <= wbyte[PA_WIDTH-1:0];
      end else if (address_in == `OFS_PA_WAKE) begin
        first_port_wake_enable_reg <= wbyte[PA_WIDTH-1:0];
      end
    end
  end

  // ************************************************************
  // Port B registers
  // ************************************************************
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      second_port_latch_reg <= `RST_PB_DATA;
      port_b_direction_reg <= `RST_PB_DIR;
      second_port_pullup_enable_reg <= `RST_PULLUP_B;
    end else if (lane0_write) begin
      if (address_in == `OFS_PB_DATA) begin
        second_port_latch_reg <= wbyte[PB_WIDTH-1:0];
      end else if (address_in == `OFS_PB_DIR) begin
        port_b_direction_reg <= wbyte[PB_WIDTH-1:0];
      end else if (address_in == `OFS_PB_PULLUP) begin
        second_port_pullup_enable_reg <= wbyte[PB_WIDTH-1:0];
      end
    end
  end

  // ************************************************************
  // Remap and converter control
  // ************************************************************
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      pin_remap_control_reg <= {`RST_LOCK_KEY, `RST_ROUTE};
    end else if (lane0_write && address_in == `OFS_REMAP) begin
      pin_remap_control_reg.remap_lock_key <= wbyte[`REMAP_KEY_MSB:`REMAP_KEY_LSB];
      if (pin_remap_control_reg.remap_lock_key == `REMAP_UNLOCK_KEY) begin
        pin_remap_control_reg[`REMAP_ROUTE_MSB:`REMAP_ROUTE_LSB] <=
          wbyte[`REMAP_ROUTE_MSB:`REMAP_ROUTE_LSB];
      end
    end
  end

  // Channels start enabled with the converter powered down
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      adc_ctrl_reg <= {`RST_ADC_CHAN, `RST_ADC_ON};
    end else if (lane0_write && address_in == `OFS_ADC_CTRL) begin
      adc_ctrl_reg <= wbyte[`ADC_ON_BIT:0];
    end
  end

  // ************************************************************
  // Wake-up
  // ************************************************************
  logic [PA_WIDTH-1:0] pa_fall;
  logic wake_event;
  assign pa_fall = pa_level_prev_reg & ~pa_level_reg & first_port_wake_enable_reg;
  assign wake_event = sleep_mode_in && (|pa_fall);

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= wake_event;
    end
  end

  // Sticky flag; a new wake beats a simultaneous clear.
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      wake_seen_reg <= 1'b0;
    end else if (wake_event) begin
      wake_seen_reg <= 1'b1;
    end else if (lane0_write && address_in == `OFS_STATUS && wbyte[0]) begin
      wake_seen_reg <= 1'b0;
    end
  end

  // ************************************************************
  // Function routing and pad drive
  // ************************************************************
  logic [PA_WIDTH-1:0] pa_adc_sel;
  logic [PA_WIDTH-1:0] pa_analog;
  logic [PA_WIDTH-1:0] pa_tm_en;
  logic [PA_WIDTH-1:0] pa_tm_val;
  logic [PB_WIDTH-1:0] pb_tm_en;
  logic [PB_WIDTH-1:0] pb_tm_val;
  logic [1:0] route;
  logic tm0_en;

  assign route = pin_remap_control_reg.timer_pin_route_select;
  assign tm0_en = TWO_TIMERS && timer_zero_pin_enable_in;
  // Converter channels sit on the low four port A pins.
  assign pa_adc_sel = {4'h0, adc_ctrl_reg.adc_channel_enable};
  assign pa_analog = pa_adc_sel | pa_comparator_select_in;

  // Timer output placement per route code
  always_comb begin
    pa_tm_en = '0;
    pa_tm_val = '0;
    pb_tm_en = '0;
    pb_tm_val = '0;
    case (route)
      2'h0: begin
        pa_tm_en[3] = tm0_en;
        pa_tm_val[3] = timer_zero_output_in;
        pa_tm_en[4] = timer_one_pin_enable_in;
        pa_tm_val[4] = timer_one_output_in;
      end
      2'h1: begin
        pb_tm_en[0] = tm0_en;
        pb_tm_val[0] = timer_zero_output_in;
        pb_tm_en[1] = timer_one_pin_enable_in;
        pb_tm_val[1] = timer_one_output_in;
      end
      2'h2: begin
        pa_tm_en[5] = tm0_en;
        pa_tm_val[5] = timer_zero_output_in;
        pa_tm_en[6] = timer_one_pin_enable_in;
        pa_tm_val[6] = timer_one_output_in;
      end
      default: begin
        pa_tm_en[2] = tm0_en;
        pa_tm_val[2] = timer_zero_output_in;
        pa_tm_en[7] = timer_one_pin_enable_in;
        pa_tm_val[7] = timer_one_output_in;
      end
    endcase
  end

  // Analog wins over every digital drive and pull-up
  genvar g;
  for (g = 0; g < PA_WIDTH; g++) begin : g_pa_pad
    always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
        pa_pin_out[g] <= 1'b1;
        pa_pin_oe_n_out[g] <= 1'b1;
        pa_pullup_out[g] <= 1'b0;
      end else begin
        pa_pin_out[g] <= pa_tm_en[g] ? pa_tm_val[g] : first_port_latch_reg[g];
        pa_pin_oe_n_out[g] <= pa_analog[g] | (port_a_direction_reg[g] & ~pa_tm_en[g]);
        pa_pullup_out[g] <= first_port_pullup_enable_reg[g] & port_a_direction_reg[g] &
          ~pa_tm_en[g] & ~pa_analog[g];
      end
    end
  end

  for (g = 0; g < PB_WIDTH; g++) begin : g_pb_pad
    always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
        pb_pin_out[g] <= 1'b1;
        pb_pin_oe_n_out[g] <= 1'b1;
        pb_pullup_out[g] <= 1'b0;
      end else begin
        pb_pin_out[g] <= pb_tm_en[g] ? pb_tm_val[g] : second_port_latch_reg[g];
        pb_pin_oe_n_out[g] <= port_b_direction_reg[g] & ~pb_tm_en[g];
        pb_pullup_out[g] <= second_port_pullup_enable_reg[g] & port_b_direction_reg[g] & ~pb_tm_en[g];
      end
    end
  end

  // Every selected analog module sees the pin at once
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      pa_adc_connect_out <= {4'h0, `RST_ADC_CHAN};
      pa_comparator_connect_out <= '0;
      adc_power_on_out <= `RST_ADC_ON;
    end else begin
      pa_adc_connect_out <= pa_adc_sel;
      pa_comparator_connect_out <= pa_comparator_select_in;
      adc_power_on_out <= adc_ctrl_reg.adc_power_on;
    end
  end

  // Digital input functions taken from the filtered pins
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      ext_irq_one_input_out <= 1'b1;
      ext_irq_zero_input_out <= 1'b1;
      timer_one_clock_input_out <= 1'b1;
      timer_zero_clock_input_out <= 1'b1;
    end else begin
      ext_irq_one_input_out <= pin_remap_control_reg.irq1_route_select ?
        pa_level_reg[`PIN_IRQ1_ALT] : pa_level_reg[`PIN_IRQ1_DEFAULT];
      ext_irq_zero_input_out <= pin_remap_control_reg.irq0_timer_clock_route_select ?
        pa_level_reg[`PIN_IRQ0_ALT] : pa_level_reg[`PIN_IRQ0_DEFAULT];
      timer_one_clock_input_out <= pin_remap_control_reg.irq0_timer_clock_route_select ?
        pa_level_reg[`PIN_IRQ0_ALT] : pa_level_reg[`PIN_IRQ0_DEFAULT];
      if (!TWO_TIMERS) begin
        timer_zero_clock_input_out <= 1'b0;
      end else if (route == 2'h0) begin
        timer_zero_clock_input_out <= pa_level_reg[4];
      end else if (route == `ROUTE_PA_B0_B1) begin
        timer_zero_clock_input_out <= pb_level_reg[1];
      end else if (route == 2'h2) begin
        timer_zero_clock_input_out <= pa_level_reg[6];
      end else begin
        timer_zero_clock_input_out <= pa_level_reg[7];
      end
    end
  end

endmodule

// ===== core/gpio_remap_cfg.svh
// Named offsets, reset values and field positions for the port and remap block.
// Assumes inclusion by bare name from the package and the top module only.
`ifndef GPIO_REMAP_CFG_SVH
`define GPIO_REMAP_CFG_SVH

// ************************************************************
// Register byte offsets on the 32-bit bus
// ************************************************************
`define OFS_PA_DATA       8'h00
`define OFS_PA_DIR        8'h04
`define OFS_PA_PULLUP     8'h08
`define OFS_PA_WAKE       8'h0c
`define OFS_PB_DATA       8'h10
`define OFS_PB_DIR        8'h14
`define OFS_PB_PULLUP     8'h18
`define OFS_REMAP         8'h1c
`define OFS_ADC_CTRL      8'h20
`define OFS_STATUS        8'h24

// ************************************************************
// Reset values
// ************************************************************
`define RST_PA_DATA       8'hff
`define RST_PA_DIR        8'hff
`define RST_PB_DATA       6'h3f
`define RST_PB_DIR        6'h3f
`define RST_PULLUP_A      8'h00
`define RST_PULLUP_B      6'h00
`define RST_WAKE          8'h00
`define RST_LOCK_KEY      4'h5
`define RST_ROUTE         4'h0
`define RST_ADC_CHAN      4'hf
`define RST_ADC_ON        1'h0

// ************************************************************
// Remap lock and field layout
// ************************************************************
`define REMAP_UNLOCK_KEY  4'ha
`define REMAP_KEY_MSB     7
`define REMAP_KEY_LSB     4
`define REMAP_ROUTE_MSB   3
`define REMAP_ROUTE_LSB   0
`define ADC_ON_BIT        4

// ************************************************************
// Routing pin indices
// ************************************************************
`define PIN_IRQ1_DEFAULT  5
`define PIN_IRQ1_ALT      4
`define PIN_IRQ0_DEFAULT  3
`define PIN_IRQ0_ALT      2
`define ROUTE_PA_B0_B1    2'h1

// ************************************************************
// Avalon response codes
// ************************************************************
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ===== core/gpio_remap_pkg.sv
// Types shared by the port and remap block.
// Assumes the cfg header sits beside it on the include path.
package gpio_remap_pkg;
  `include "gpio_remap_cfg.svh"

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;

  typedef struct packed {
    logic [3:0] remap_lock_key;
    logic irq1_route_select;
    logic irq0_timer_clock_route_select;
    logic [1:0] timer_pin_route_select;
  } remap_t;

  typedef struct packed {
    logic [3:0] adc_channel_enable;
    logic adc_power_on;
  } adc_ctrl_t;
endpackage

// ===== verif/gpio_direction_and_pin_remap_bench.sv
// Self-checking bench for the port and remap block.
// Assumes the checker is bound in and the board model drives the pads.
`timescale 1ns/100ps
module gpio_direction_and_pin_remap_bench;
  logic clock_in = 1'b0, rstn_in = 1'b0, read_in = 1'b0, write_in = 1'b0, sleep_mode_in = 1'b0;
  logic timer_zero_output_in = 1'b0, timer_zero_pin_enable_in = 1'b0;
  logic timer_one_output_in = 1'b0, timer_one_pin_enable_in = 1'b0;
  logic waitrequest_out, wake_out, adc_power_on_out, ext_irq_zero_input_out, ext_irq_one_input_out;
  logic timer_zero_clock_input_out, timer_one_clock_input_out;
  logic [7:0] address_in = 8'h00, pa_comparator_select_in = 8'h00, pa_drive = 8'hff, rv, d;
  logic [7:0] pa_pin_in, pa_pin_out, pa_pin_oe_n_out, pa_pullup_out, pa_adc_connect_out, pa_comparator_connect_out;
  logic [5:0] pb_pin_in, pb_pin_out, pb_pin_oe_n_out, pb_pullup_out;
  logic [13:0] pins;
  logic [31:0] writedata_in = 32'h0, readdata_out;
  logic [3:0] byteenable_in = 4'h0, be = 4'h1;
  logic [1:0] response_out;
  logic [9:0] exp_q[$];
  logic [9:0] exp_e;
  logic seen;
  int error_cnt = 0, cmp_count = 0, seed = 32'hbee6;
  int t0_idx[4] = '{3, 8, 5, 2};
  int t1_idx[4] = '{4, 9, 6, 7};
  assign pins = {pb_pin_out, pa_pin_out};
  gpio_direction_and_pin_remap DUT (.*);
  pin_board_model #(.W(8)) board_a (.clock_in, .pin_out_in(pa_pin_out), .oe_n_in(pa_pin_oe_n_out),
    .pullup_in(pa_pullup_out), .drive_in(pa_drive), .drive_en_in(8'hff), .level_out(pa_pin_in));
  pin_board_model #(.W(6)) board_b (.clock_in, .pin_out_in(pb_pin_out), .oe_n_in(pb_pin_oe_n_out),
    .pullup_in(pb_pullup_out), .drive_in(6'h2a), .drive_en_in(6'h0f), .level_out(pb_pin_in));
  initial begin
    forever #25 clock_in = !clock_in;
  end
  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Master holds the request until it samples waitrequest low
  task automatic bus(logic rd, logic [7:0] adr, logic [7:0] wd, logic [7:0] exp, logic [1:0] rsp);
    int n;
    n = 0;
    if (rd)
      exp_q.push_back({exp, rsp});
    read_in <= rd;
    write_in <= !rd;
    address_in <= adr;
    writedata_in <= {24'h0, wd};
    byteenable_in <= be;
    do begin
      @(posedge clock_in);
      n++;
    end while (waitrequest_out !== 1'b0 && n < 20);
    rv = readdata_out[7:0];
    if (waitrequest_out !== 1'b0) begin
      error_cnt++;
      conclude();
    end else begin
      read_in <= 1'b0;
      write_in <= 1'b0;
      @(posedge clock_in);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    bus(1'b0, a, v, 8'h00, 2'h0);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    bus(1'b1, a, 8'h00, e, 2'h0);
  endtask
  task automatic settle;
    repeat (6) @(posedge clock_in);
  endtask
  always @(posedge clock_in) begin
    if (read_in && waitrequest_out === 1'b0 && exp_q.size() > 0) begin
      exp_e = exp_q.pop_front();
      chk("readdata", {24'h0, exp_e[9:2]}, readdata_out);
      chk("response", {30'h0, exp_e[1:0]}, {30'h0, response_out});
    end
  end
  initial begin
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    rd(8'h04, 8'hff);
    rd(8'h14, 8'h3f);
    rd(8'h1c, 8'h50);
    rd(8'h20, 8'h1e);
    rd(8'h0c, 8'h00);
    rd(8'h18, 8'h00);
    bus(1'b1, 8'h30, 8'h00, 8'h00, 2'h2);
    wr(8'h20, 8'h00);
    wr(8'h04, 8'h0f);
    be = 4'h0;
    wr(8'h04, 8'hff);
    be = 4'h1;
    rd(8'h04, 8'h0f);
    chk("pa_pin_out", 8'hff, pa_pin_out);
    wr(8'h14, 8'hc0);
    rd(8'h14, 8'h00);
    chk("pb_pin_oe_n_out", 6'h00, pb_pin_oe_n_out);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      pa_drive <= 8'($random(seed));
      wr(8'h00, d);
      settle();
      rd(8'h00, (d & 8'hf0) | (pa_drive & 8'h0f));
    end
    rd(8'h04, 8'h0f);
    wr(8'h04, rv & 8'hfe);
    rd(8'h04, 8'h0e);
    wr(8'h04, 8'hff);
    wr(8'h08, 8'hff);
    pa_drive <= 8'hff;
    wr(8'h0c, 8'h01);
    settle();
    chk("pa_pullup_out", 8'hff, pa_pullup_out);
    sleep_mode_in <= 1'b1;
    pa_drive <= 8'hfe;
    seen = 1'b0;
    repeat (12) begin
      @(posedge clock_in);
      if (wake_out === 1'b1)
        seen = 1'b1;
    end
    chk("wake_out", 1'b1, seen);
    rd(8'h24, 8'h01);
    sleep_mode_in <= 1'b0;
    wr(8'h20, 8'h1f);
    settle();
    chk("pa_pullup_out", 8'hf0, pa_pullup_out);
    chk("adc_power_on_out", 1'b1, adc_power_on_out);
    wr(8'h20, 8'h00);
    wr(8'h1c, 8'h0c);
    rd(8'h1c, 8'h00);
    wr(8'h1c, 8'ha0);
    for (int s = 0; s < 16; s++) begin
      pa_drive <= 8'($random(seed));
      pa_comparator_select_in <= 8'($random(seed));
      wr(8'h1c, 8'ha0 | 8'(s));
      settle();
      rd(8'h1c, 8'ha0 | 8'(s));
      chk("ext_irq_one", pa_drive[s[3] ? 4 : 5], ext_irq_one_input_out);
      chk("ext_irq_zero", pa_drive[s[2] ? 2 : 3], ext_irq_zero_input_out);
      chk("timer_one_clock", pa_drive[s[2] ? 2 : 3], timer_one_clock_input_out);
    end
    pa_comparator_select_in <= 8'h00;
    timer_zero_pin_enable_in <= 1'b1;
    timer_one_pin_enable_in <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      timer_zero_output_in <= s[2];
      timer_one_output_in <= !s[2];
      wr(8'h1c, 8'ha0 | 8'(s[1:0]));
      settle();
      chk("timer_zero_pin", s[2], pins[t0_idx[s[1:0]]]);
      chk("timer_one_pin", !s[2], pins[t1_idx[s[1:0]]]);
      chk("timer_zero_clock", !s[2], timer_zero_clock_input_out);
    end
    timer_zero_pin_enable_in <= 1'b0;
    timer_one_pin_enable_in <= 1'b0;
    wr(8'h1c, 8'h50);
    wr(8'h1c, 8'h5f);
    rd(8'h1c, 8'h50);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    rd(8'h04, 8'hff);
    conclude();
  end
endmodule

// ===== verif/gpio_remap_sva.sv
// Checker for the port and remap block, bound to its top module.
// Assumes timer pin enables stay low around direction writes.
`timescale 1ns/100ps
module gpio_remap_sva #(
  parameter int PA_WIDTH = 8
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [7:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  input wire logic [31:0] readdata_out,
  input wire logic waitrequest_out,
  input wire logic [PA_WIDTH-1:0] pa_pin_out,
  input wire logic [PA_WIDTH-1:0] pa_pin_oe_n_out,
  input wire logic [PA_WIDTH-1:0] pa_pullup_out,
  input wire logic [PA_WIDTH-1:0] pa_comparator_select_in,
  input wire logic [PA_WIDTH-1:0] pa_adc_connect_out,
  input wire logic [PA_WIDTH-1:0] pa_comparator_connect_out,
  input wire logic adc_power_on_out,
  input wire logic wake_out
);
  logic [PA_WIDTH-1:0] analog;
  logic [PA_WIDTH-1:0] wd_low;
  assign analog = pa_adc_connect_out | pa_comparator_connect_out;
  assign wd_low = writedata_in[PA_WIDTH-1:0];
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  analog_wins_a:
    assert property ((analog & ~pa_pin_oe_n_out) == '0) else $error("Analog pin is driven");
  adc_no_pullup_a:
    assert property ((pa_adc_connect_out & pa_pullup_out) == '0) else $error("Pull-up on converter pin");
  cmp_follow_a:
    assert property ($past(rstn_in) |-> pa_comparator_connect_out == $past(pa_comparator_select_in))
      else $error("Comparator not connected");
  adc_reset_a:
    assert property (!$past(rstn_in) |-> !adc_power_on_out && pa_adc_connect_out == 8'h0f)
      else $error("Converter reset state wrong");
  pins_reset_a:
    assert property (!$past(rstn_in) |-> &pa_pin_out && &pa_pin_oe_n_out) else $error("Pins not high input");
  pullup_reset_a:
    assert property (!$past(rstn_in) |-> pa_pullup_out == '0 && !wake_out) else $error("Enables not cleared");
  pb_upper_zero_a:
    assert property (read_in && !waitrequest_out && address_in == 8'h14 |-> readdata_out[7:6] == 2'h0)
      else $error("Port B direction upper bits set");
  dir_to_pad_a:
    assert property (write_in && !waitrequest_out && address_in == 8'h04 && byteenable_in[0]
      |-> ##2 (pa_pin_oe_n_out | analog) == ($past(wd_low, 2) | analog)) else $error("Direction not on pad");
  wake_pulse_a:
    assert property (wake_out |=> !wake_out) else $error("Wake pulse too long");
endmodule

bind gpio_direction_and_pin_remap gpio_remap_sva #(.PA_WIDTH(PA_WIDTH)) checker_i (.*);

// ===== verif/pin_board_model.sv
// Board side of one port: external drivers, pull-ups and floating pads.
// Assumes the bench chooses which pads the board drives.
`timescale 1ns/100ps
module pin_board_model #(
  parameter int W = 8
) (
  input wire logic clock_in,
  input wire logic [W-1:0] pin_out_in,
  input wire logic [W-1:0] oe_n_in,
  input wire logic [W-1:0] pullup_in,
  input wire logic [W-1:0] drive_in,
  input wire logic [W-1:0] drive_en_in,
  output logic [W-1:0] level_out
);
  logic flip_reg = 1'b0;
  always_ff @(posedge clock_in) begin
    flip_reg <= !flip_reg;
  end
  // Floating pads wander each cycle, so a stale level never passes
  always_comb begin
    for (int i = 0; i < W; i++) begin
      level_out[i] = !oe_n_in[i] ? pin_out_in[i] : drive_en_in[i] ? drive_in[i] : pullup_in[i] | flip_reg;
    end
  end
endmodule
